// file: verilog/dpc_timer.sv
// top of the dual pulse capture timer: apb slave, clock selection, irq
`timescale 1ns/10ps
// ------------------------------------------------------------
// How it works
// (RQ1) each channel times the input pulse and reports period or width as a count
// (RQ2) two channels run independently with own config, counter, flags, irq controls
// (RQ3) channel zero picks sub, main, timer two or channel one's source; one picks others; code gives channel zero channel one's divided tick
// (RQ4) selected clock divided by 1, 8, 32 or 64 via two-bit divisor field
// (RQ5) period measured between successive rising or successive falling edges
// (RQ6) width mode measures each high level and each low level
// (RQ7) polarity select optionally inverts the input before edge detection
// (RQ8) per-channel digital noise filter, enabled by its filter bit
// (RQ9) overflow irq only when its enable bit is set; measurement always raises irq; code sets the status bit always, irq only if its mask bit is set
// (RQ10) pattern-match status flags unused and read as undefined filler
// (RQ11) counter counts up from zero to all ones, wraps and continues
// (RQ12) overflow flag set on wrap, held until next measurement edge; code also clears it when the channel is disabled
// (RQ13) measured value readable as 16 bits in the result register
// (RQ14) measurement edge latches count, restarts from zero, flags the event
// (RQ15) counter advances once per divided source tick while enabled
// ------------------------------------------------------------
module dpc_timer
	import dpc_pkg::*;
#(
	parameter int NCH = 2
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// count sources (asynchronous levels)
	input wire logic sub_clock,
	input wire logic main_peripheral_clock,
	input wire logic timer_one_underflow,
	input wire logic timer_two_underflow,
	// pulse inputs
	input wire logic [NCH-1:0] pulse_in,
	// status and interrupt
	output logic [NCH-1:0] running_flag,
	output logic [NCH-1:0] input_level_flag,
	output logic [NCH-1:0] overflow_flag,
	output logic irq
);

	initial begin
		if (NCH != 2) $error("dpc_timer: exactly two channels are supported");
	end

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	localparam int NS = 4 + NCH;
	logic [NS-1:0] sy1_q;
	logic [NS-1:0] sy2_q;
	logic [NS-1:0] sy3_q;
	logic [3:0] src_tick;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sy1_q <= '0;
			sy2_q <= '0;
			sy3_q <= '0;
		end else begin
			sy1_q <= {pulse_in, timer_two_underflow, timer_one_underflow,
				main_peripheral_clock, sub_clock};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	// source ticks on rising edges of synchronised sources
	assign src_tick = sy2_q[3:0] & ~sy3_q[3:0];

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	dpc_ctrl_t ctrl_q [NCH];
	dpc_chan_st_t st [NCH];
	logic [NCH-1:0] dtick;
	logic [NCH-1:0] sel_tick;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_set;
	logic wr_acc;
	logic rd_acc;

	assign wr_acc = psel && penable && pwrite;
	// read-clear at the setup edge, where prdata takes the old status
	assign rd_acc = psel && !penable && !pwrite;

	// channel zero sources: sub, main, timer two, channel one's divided tick
	always_comb begin
		case (ctrl_q[0].src)
			2'h0: sel_tick[0] = src_tick[0];
			2'h1: sel_tick[0] = src_tick[1];
			2'h2: sel_tick[0] = src_tick[3];
			default: sel_tick[0] = dtick[1];
		endcase // [RQ3]
	end

	// channel one sources: sub, main, timer one, timer two
	always_comb begin
		case (ctrl_q[1].src)
			2'h0: sel_tick[1] = src_tick[0];
			2'h1: sel_tick[1] = src_tick[1];
			2'h2: sel_tick[1] = src_tick[2];
			default: sel_tick[1] = src_tick[3];
		endcase // [RQ3]
	end

	// ------------------------------------------------------------
	// channels
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			localparam logic [7:0] CTRL_ADR = OFS_CH0_CTRL + 8'(g) * OFS_CH_STRIDE;

			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					ctrl_q[g] <= CTL_RESET;
				end else if (wr_acc && paddr == CTRL_ADR) begin
					ctrl_q[g] <= pwdata[CTL_W-1:0]; // [RQ2]
				end
			end

			dpc_channel #(
				.CW(CNT_W)
			) u_ch (
				.clk_sys(clk_sys),
				.rst(rst),
				.ctrl(ctrl_q[g]),
				.src_tick(sel_tick[g]),
				.pulse_in(sy2_q[4+g]),
				.st(st[g]),
				.div_tick(dtick[g])
			); // [RQ2]

			assign irq_set[2*g] = st[g].meas; // [RQ9]
			assign irq_set[2*g+1] = st[g].ovf && ctrl_q[g].ovf_ie; // [RQ9]

			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					running_flag[g] <= 1'b0;
					input_level_flag[g] <= 1'b0;
					overflow_flag[g] <= 1'b0;
				end else begin
					running_flag[g] <= st[g].run;
					input_level_flag[g] <= st[g].level;
					if (st[g].meas || !ctrl_q[g].en) begin
						overflow_flag[g] <= 1'b0; // [RQ12]
					end else if (st[g].ovf) begin
						overflow_flag[g] <= 1'b1; // [RQ12]
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_mask_q <= '0;
		end else if (wr_acc && paddr == OFS_IRQ_MASK) begin
			irq_mask_q <= pwdata[IRQ_W-1:0];
		end
	end

	// set wins over the read-clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_stat_q <= '0;
		end else if (rd_acc && paddr == OFS_IRQ_STAT) begin
			irq_stat_q <= irq_set; // [RQ9]
		end else begin
			irq_stat_q <= irq_stat_q | irq_set; // [RQ9]
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ------------------------------------------------------------
	// apb read path
	// ------------------------------------------------------------
	function automatic logic [31:0] stat_word(input dpc_chan_st_t s, input logic ovf);
		logic [31:0] w;
		w = '0;
		w[STS_RUN] = s.run;
		w[STS_LEVEL] = s.level;
		w[STS_OVF] = ovf;
		w[STS_PM_LO +: STS_PM_W] = PM_FILLER; // [RQ10]
		return w;
	endfunction

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= '0;
			if (psel && !penable) begin
				case (paddr)
					OFS_CH0_CTRL: prdata <= {22'h000000, ctrl_q[0]};
					OFS_CH1_CTRL: prdata <= {22'h000000, ctrl_q[1]};
					OFS_CH0_STAT: prdata <= stat_word(st[0], overflow_flag[0]);
					OFS_CH1_STAT: prdata <= stat_word(st[1], overflow_flag[1]);
					OFS_CH0_RES: prdata <= {16'h0000, st[0].result}; // [RQ13]
					OFS_CH1_RES: prdata <= {16'h0000, st[1].result}; // [RQ13]
					OFS_IRQ_STAT: prdata <= {28'h0000000, irq_stat_q};
					OFS_IRQ_MASK: prdata <= {28'h0000000, irq_mask_q};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule

// file: verilog/dpc_pkg.sv
// package for the dual pulse capture timer: register map, fields, types
package dpc_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CH0_CTRL = 8'h00;
	localparam logic [7:0] OFS_CH0_STAT = 8'h04;
	localparam logic [7:0] OFS_CH0_RES = 8'h08;
	localparam logic [7:0] OFS_CH1_CTRL = 8'h10;
	localparam logic [7:0] OFS_CH1_STAT = 8'h14;
	localparam logic [7:0] OFS_CH1_RES = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	localparam logic [7:0] OFS_CH_STRIDE = 8'h10;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CTL_EN = 0;
	localparam int CTL_POL = 1;
	localparam int CTL_FIL = 2;
	localparam int CTL_TYP_LO = 3;
	localparam int CTL_SRC_LO = 5;
	localparam int CTL_DIV_LO = 7;
	localparam int CTL_OVF_IE = 9;
	localparam int CTL_W = 10;
	localparam logic [CTL_W-1:0] CTL_RESET = 10'h000;

	// status register fields
	localparam int STS_RUN = 0;
	localparam int STS_LEVEL = 1;
	localparam int STS_OVF = 2;
	localparam int STS_PM_LO = 8;
	localparam int STS_PM_W = 8;
	// pattern-match flags are unused here: they read as this arbitrary filler
	localparam logic [STS_PM_W-1:0] PM_FILLER = 8'h00;

	// irq status/mask layout: per channel two bits (measure, overflow)
	localparam int IRQ_W = 4;

	// measuring object encodings
	localparam logic [1:0] TYP_RISE = 2'h0;
	localparam logic [1:0] TYP_FALL = 2'h1;
	localparam logic [1:0] TYP_WIDTH = 2'h2;

	// divisor encodings and ratios
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_8 = 2'h1;
	localparam logic [1:0] DIV_32 = 2'h2;
	localparam logic [1:0] DIV_64 = 2'h3;
	localparam logic [5:0] DIV_8_TC = 6'h07;
	localparam logic [5:0] DIV_32_TC = 6'h1f;
	localparam logic [5:0] DIV_64_TC = 6'h3f;

	// digital filter: samples of equal level before the output follows
	localparam int FILT_LEN = 3;

	// counter
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

	typedef struct packed {
		logic ovf_ie;
		logic [1:0] div;
		logic [1:0] src;
		logic [1:0] typ;
		logic filter_enable_bit;
		logic pol;
		logic en;
	} dpc_ctrl_t;

	typedef struct packed {
		logic meas;
		logic ovf;
		logic run;
		logic level;
		logic [CNT_W-1:0] result;
	} dpc_chan_st_t;

endpackage

// file: verilog/dpc_channel.sv
// one pulse capture channel: conditioning, divider, counter, capture
`timescale 1ns/10ps
module dpc_channel
	import dpc_pkg::*;
#(
	parameter int CW = CNT_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// configuration and count source tick (selected source, undivided)
	input wire dpc_ctrl_t ctrl,
	input wire logic src_tick,
	// synchronised pulse input
	input wire logic pulse_in,
	// state out
	output dpc_chan_st_t st,
	output logic div_tick
);

	initial begin
		if (CW != CNT_W) $error("dpc_channel: counter width must be %0d", CNT_W);
	end

	logic [5:0] div_q;
	logic [CW-1:0] cnt_q;
	logic [FILT_LEN-1:0] fsh_q;
	logic filt_q;
	logic lvl_q;
	logic prev_q;
	logic run_q;
	logic [CW-1:0] res_q;
	logic cond;
	logic edge_ev;
	logic [5:0] tc;

	// ------------------------------------------------------------
	// divider
	// ------------------------------------------------------------
	always_comb begin
		case (ctrl.div)
			DIV_8: tc = DIV_8_TC;
			DIV_32: tc = DIV_32_TC;
			DIV_64: tc = DIV_64_TC;
			default: tc = 6'h00;
		endcase
	end

	assign div_tick = src_tick && (div_q >= tc); // [RQ4]

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_q <= 6'h00;
		end else if (!ctrl.en) begin
			div_q <= 6'h00;
		end else if (src_tick) begin
			div_q <= (div_q >= tc) ? 6'h00 : div_q + 6'h01; // [RQ4]
		end
	end

	// ------------------------------------------------------------
	// input conditioning
	// ------------------------------------------------------------
	assign cond = ctrl.filter_enable_bit ? filt_q : (pulse_in ^ ctrl.pol); // [RQ7] [RQ8]

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fsh_q <= '0;
			filt_q <= 1'b0;
		end else if (div_tick) begin
			fsh_q <= {fsh_q[FILT_LEN-2:0], pulse_in ^ ctrl.pol}; // [RQ7]
			if (&fsh_q) begin
				filt_q <= 1'b1; // [RQ8]
			end else if (~|fsh_q) begin
				filt_q <= 1'b0; // [RQ8]
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lvl_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			lvl_q <= cond;
			prev_q <= lvl_q;
		end
	end

	// ------------------------------------------------------------
	// edge selection
	// ------------------------------------------------------------
	always_comb begin
		case (ctrl.typ)
			TYP_RISE: edge_ev = lvl_q && !prev_q; // [RQ5]
			TYP_FALL: edge_ev = !lvl_q && prev_q; // [RQ5]
			TYP_WIDTH: edge_ev = lvl_q ^ prev_q; // [RQ6]
			default: edge_ev = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// counter, capture and overflow
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= CNT_ZERO;
			res_q <= CNT_ZERO;
			run_q <= 1'b0;
		end else begin
			run_q <= ctrl.en;
			if (!ctrl.en) begin
				cnt_q <= CNT_ZERO;
			end else if (edge_ev && run_q) begin
				res_q <= cnt_q; // [RQ1] [RQ13] [RQ14]
				cnt_q <= CNT_ZERO; // [RQ14]
			end else if (div_tick) begin
				cnt_q <= cnt_q + 16'h0001; // [RQ11] [RQ15]
			end
		end
	end

	assign st.meas = ctrl.en && run_q && edge_ev; // [RQ14]
	assign st.ovf = ctrl.en && !edge_ev && div_tick && cnt_q == CNT_MAX; // [RQ12]
	assign st.run = run_q;
	assign st.level = lvl_q;
	assign st.result = res_q;

endmodule

// file: sim/dpc_timer_checker.sv
// assertion checker for the dual pulse capture timer ports
`timescale 1ns/10ps
module dpc_timer_checker
	import dpc_pkg::*;
#(
	parameter int NCH = 2
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// flags
	input wire logic [NCH-1:0] running_flag,
	input wire logic [NCH-1:0] overflow_flag
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic mapped;
	assign mapped = paddr inside {OFS_CH0_CTRL, OFS_CH0_STAT, OFS_CH0_RES, OFS_CH1_CTRL,
		OFS_CH1_STAT, OFS_CH1_RES, OFS_IRQ_STAT, OFS_IRQ_MASK};
	property p_rdy_lat;
		psel && !penable |=> pready;
	endproperty
	a_rdy_lat: assert property (p_rdy_lat) else $error("no answer after setup");
	property p_rdy_one;
		pready |=> !pready;
	endproperty
	a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
	property p_rdy_acc;
		pready |-> psel && penable;
	endproperty
	a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
	property p_err_map;
		pready |-> (pslverr == !mapped);
	endproperty
	a_err_map: assert property (p_err_map) else $error("pslverr does not match address");
	property p_rd_idle;
		!pready |-> prdata == 32'h00000000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
	property p_res_w;
		pready && !pwrite && (paddr == OFS_CH0_RES || paddr == OFS_CH1_RES)
			|-> prdata[31:16] == 16'h0000;
	endproperty
	a_res_w: assert property (p_res_w) else $error("result wider than 16 bits");
	property p_pm_fill;
		pready && !pwrite && (paddr == OFS_CH0_STAT || paddr == OFS_CH1_STAT)
			|-> prdata[15:8] == PM_FILLER;
	endproperty
	a_pm_fill: assert property (p_pm_fill) else $error("pattern flags not filler");
	property p_ovf0;
		$rose(overflow_flag[0]) |-> running_flag[0];
	endproperty
	a_ovf0: assert property (p_ovf0) else $error("overflow on idle channel zero");
	property p_ovf1;
		$rose(overflow_flag[1]) |-> running_flag[1];
	endproperty
	a_ovf1: assert property (p_ovf1) else $error("overflow on idle channel one");
endmodule
bind dpc_timer dpc_timer_checker #(.NCH(NCH)) dpc_timer_checker_i (.clk_sys(clk_sys),
	.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .running_flag(running_flag),
	.overflow_flag(overflow_flag));

// file: sim/dpc_pulse_model.sv
// behavioural model of the external pulse source of one channel
`timescale 1ns/10ps
module dpc_pulse_model (
	// clock
	input wire logic clk_sys,
	// shape in clock cycles
	input wire logic run,
	input wire logic [15:0] hi_len,
	input wire logic [15:0] lo_len,
	// pulse out
	output logic pulse
);
	logic [15:0] cnt_q = 16'h0001;
	initial pulse = 1'b0;
	always @(posedge clk_sys) begin
		if (!run) begin
			pulse <= 1'b0;
			cnt_q <= 16'h0001;
		end else if (cnt_q >= (pulse ? hi_len : lo_len)) begin
			pulse <= ~pulse;
			cnt_q <= 16'h0001;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
endmodule

// file: sim/dpc_timer_tb.sv
// self-checking testbench for the dual pulse capture timer
`timescale 1ns/10ps
module dpc_timer_tb;
	import dpc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, irq, er;
	logic [7:0] tcnt = 8'h00;
	wire [1:0] pulse_in;
	logic [1:0] running_flag, input_level_flag, overflow_flag;
	logic [1:0] gen_run = 2'h0;
	logic [15:0] hl0 = 16'h0010, ll0 = 16'h0030, hl1 = 16'h0028, ll1 = 16'h0028;
	logic [31:0] rd;
	int errors = 0;
	int num_checks = 0;
	// ----
	// clock, count sources, instances
	// ----
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) tcnt <= tcnt + 8'h01;
	dpc_timer dpc_timer_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sub_clock(tcnt[2]), .main_peripheral_clock(tcnt[1]),
		.timer_one_underflow(tcnt[3]), .timer_two_underflow(tcnt[4]), .pulse_in(pulse_in),
		.running_flag(running_flag), .input_level_flag(input_level_flag),
		.overflow_flag(overflow_flag), .irq(irq));
	dpc_pulse_model dpc_pulse_model_i (.clk_sys(clk_sys), .run(gen_run[0]), .hi_len(hl0),
		.lo_len(ll0), .pulse(pulse_in[0]));
	dpc_pulse_model dpc_pulse_model_i1 (.clk_sys(clk_sys), .run(gen_run[1]), .hi_len(hl1),
		.lo_len(ll1), .pulse(pulse_in[1]));
	// ----
	// shared tasks
	// ----
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got,
		input int tol);
		num_checks++;
		if ($isunknown(got) || got + tol < exp || got > exp + tol) begin
			errors++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			tally_and_finish();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset;
		apb(1'b0, OFS_CH0_CTRL, 32'h0);
		chk("ctrl0", 32'h0, rd, 0);
		apb(1'b0, OFS_CH1_STAT, 32'h0);
		chk("stat1", 32'h0, rd, 0);
		apb(1'b0, 8'h30, 32'h0);
		chk("slverr", 32'h1, {31'h0, er}, 0);
		$display("test reset done");
	endtask
	task automatic t_period;
		gen_run[0] <= 1'b1;
		apb(1'b1, OFS_IRQ_MASK, 32'h1);
		apb(1'b1, OFS_CH0_CTRL, 32'h21);
		repeat (4) @(posedge clk_sys);
		chk("run0", 32'h1, {31'h0, running_flag[0]}, 0);
		repeat (400) @(posedge clk_sys);
		apb(1'b0, OFS_CH0_RES, 32'h0);
		chk("res0 rise", 32'h10, rd, 1);
		chk("ovf0 idle", 32'h0, {31'h0, overflow_flag[0]}, 0);
		gen_run[0] <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk("irq on", 32'h1, {31'h0, irq}, 0);
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk("irq stat", 32'h1, rd, 0);
		repeat (3) @(posedge clk_sys);
		chk("irq off", 32'h0, {31'h0, irq}, 0);
		$display("test period done");
	endtask
	task automatic t_fall_div;
		hl0 <= 16'h0100;
		ll0 <= 16'h0300;
		gen_run[0] <= 1'b1;
		apb(1'b1, OFS_CH0_CTRL, 32'h89);
		repeat (4000) @(posedge clk_sys);
		apb(1'b0, OFS_CH0_RES, 32'h0);
		chk("res0 fall div8", 32'h10, rd, 1);
		gen_run[0] <= 1'b0;
		apb(1'b1, OFS_CH0_CTRL, 32'h0);
		repeat (4) @(posedge clk_sys);
		chk("run0 off", 32'h0, {31'h0, running_flag[0]}, 0);
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		$display("test fall divider done");
	endtask
	task automatic t_width;
		int lows;
		gen_run[1] <= 1'b1;
		apb(1'b1, OFS_CH1_CTRL, 32'h37);
		repeat (400) @(posedge clk_sys);
		apb(1'b0, OFS_CH1_RES, 32'h0);
		chk("res1 width", 32'ha, rd, 1);
		chk("irq masked", 32'h0, {31'h0, irq}, 0);
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk("irq stat ch1", 32'h4, rd & 32'h5, 0);
		gen_run[1] <= 1'b0;
		repeat (40) @(posedge clk_sys);
		chk("level1", 32'h1, {31'h0, input_level_flag[1]}, 0);
		apb(1'b0, OFS_CH1_STAT, 32'h0);
		chk("stat1 level", 32'h1, {31'h0, rd[STS_LEVEL]}, 0);
		hl1 <= 16'h0002;
		ll1 <= 16'h0030;
		gen_run[1] <= 1'b1;
		lows = 0;
		repeat (70) begin
			@(posedge clk_sys);
			if (input_level_flag[1] !== 1'b1) lows++;
		end
		chk("glitch held", 32'h0, lows, 0);
		gen_run[1] <= 1'b0;
		$display("test width done");
	endtask
	// ----
	// main sequence and watchdog
	// ----
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_period();
		t_fall_div();
		t_width();
		tally_and_finish();
	end
	initial begin
		#2000000;
		errors++;
		tally_and_finish();
	end
endmodule
